// ### rtl/scs_pkg.sv
package scs_pkg;
  // ==========================================
  // Widths
  localparam int CH_W = 10;
  localparam int IV_W = 20;
  localparam int KEY_W = 5;
  localparam int ADDR_W = 8;
  localparam int TICK_W = 18;

  // ==========================================
  // Key codes; codes below ten are the digits
  localparam logic [KEY_W-1:0] KEY_DIGIT_LIM = 5'h0a;
  localparam logic [KEY_W-1:0] KEY_ENTER = 5'h0a;
  localparam logic [KEY_W-1:0] KEY_FIRST = 5'h0b;
  localparam logic [KEY_W-1:0] KEY_LAST = 5'h0c;
  localparam logic [KEY_W-1:0] KEY_INTERVAL = 5'h0d;
  localparam logic [KEY_W-1:0] KEY_PROGRAM = 5'h0e;
  localparam logic [KEY_W-1:0] KEY_CHANNEL = 5'h0f;
  localparam logic [KEY_W-1:0] KEY_SINGLE = 5'h10;
  localparam logic [KEY_W-1:0] KEY_CONT = 5'h11;
  localparam logic [KEY_W-1:0] KEY_RUNSTOP = 5'h12;
  localparam logic [KEY_W-1:0] KEY_RESET = 5'h13;
  localparam logic [KEY_W-1:0] KEY_DATE = 5'h14;
  localparam logic [KEY_W-1:0] KEY_TIME = 5'h15;
  localparam logic [3:0] PROG_POLES = 4'h6;

  // ==========================================
  // States and modes
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DWELL = 2'b01, ST_OPEN = 2'b10, ST_HALT = 2'b11
  } scs_state_t;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00, MODE_STEP = 2'b01, MODE_SINGLE = 2'b10, MODE_CONT = 2'b11
  } scs_mode_t;
  typedef enum logic [1:0] {
    EN_IDLE = 2'b00, EN_PROG = 2'b01, EN_POLES = 2'b10, EN_IVAL = 2'b11
  } scs_entry_t;

  // ==========================================
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ==========================================
  // Limits and reset values
  localparam logic [IV_W-1:0] IVAL_MIN_MS = 20'h0000a;
  localparam logic [IV_W-1:0] IVAL_MAX_MS = 20'hf423f;
  localparam logic [IV_W-1:0] IVAL_RST = 20'h003e8;
  localparam logic [CH_W-1:0] FIRST_RST = 10'h001;
  localparam logic [CH_W-1:0] LAST_RST = 10'h00a;
  localparam logic [2:0] POLES_RST = 3'h1;
  localparam int DIGITS = 6;

  // ==========================================
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] REG_KEY = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CHAN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FIRST = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_LAST = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IVAL = 8'h14;
  localparam logic [ADDR_W-1:0] REG_POLES = 8'h18;
endpackage

// ### rtl/scs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scs_link_if;
  import scs_pkg::*;
  logic key_v;
  logic [KEY_W-1:0] key_code;
  logic tick;
  logic tick_hold;
  logic [CH_W-1:0] first_ch;
  logic [CH_W-1:0] last_ch;
  logic [IV_W-1:0] ival_ms;
  logic [2:0] poles;
  modport seq (output key_v, key_code, tick_hold,
               input tick, first_ch, last_ch, ival_ms, poles);
  modport entry (input key_v, key_code,
                 output first_ch, last_ch, ival_ms, poles);
  modport timer (input tick_hold, output tick);
endinterface
`default_nettype wire

// ### rtl/scs_tick.sv
`timescale 1ns/1ps
`default_nettype none
module scs_tick #(
  parameter int TICKS = scs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link
  scs_link_if.timer lnk
);
  import scs_pkg::*;
  logic [TICK_W-1:0] cnt;

  // ==========================================
  // Millisecond tick; held in phase zero outside a dwell so every interval is exact
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || lnk.tick_hold) begin
      cnt <= '0;
      lnk.tick <= 1'b0;
    end else if (cnt == TICK_W'(TICKS - 1)) begin
      cnt <= '0;
      lnk.tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      lnk.tick <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lnk.tick |-> cnt == '0) else $error("tick not aligned to count wrap");
endmodule // scs_tick
`default_nettype wire

// ### rtl/scs_entry.sv
`timescale 1ns/1ps
`default_nettype none
module scs_entry (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link
  scs_link_if.entry lnk
);
  import scs_pkg::*;
  logic [3:0] dig [DIGITS];
  scs_entry_t en_state;
  logic [IV_W-1:0] val6;
  logic [IV_W-1:0] val3;

  function automatic logic [IV_W-1:0] bcd_val(input logic [3:0] d [DIGITS], input int n);
    logic [IV_W-1:0] acc;
    acc = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      if (i < n) begin
        acc = acc * 20'h0000a + {16'h0000, d[i]};
      end
    end
    return acc;
  endfunction

  assign val6 = bcd_val(dig, DIGITS);
  assign val3 = bcd_val(dig, 3);

  // ==========================================
  // Digit buffer, newest digit in position zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DIGITS; i++) dig[i] <= 4'h0;
    end else if (lnk.key_v) begin
      if (lnk.key_code < KEY_DIGIT_LIM && en_state != EN_PROG) begin
        dig[0] <= lnk.key_code[3:0];
        for (int i = 1; i < DIGITS; i++) dig[i] <= dig[i-1];
      end else if (lnk.key_code >= KEY_DIGIT_LIM || en_state == EN_PROG) begin
        for (int i = 0; i < DIGITS; i++) dig[i] <= 4'h0;
      end
    end
  end

  // ==========================================
  // Entry state and stored settings
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_state <= EN_IDLE;
      lnk.first_ch <= FIRST_RST;
      lnk.last_ch <= LAST_RST;
      lnk.ival_ms <= IVAL_RST;
      lnk.poles <= POLES_RST;
    end else if (lnk.key_v) begin
      case (lnk.key_code)
        KEY_PROGRAM: en_state <= EN_PROG;
        KEY_INTERVAL: en_state <= EN_IVAL;
        KEY_FIRST: begin
          if (val3 != '0) lnk.first_ch <= val3[CH_W-1:0];
          en_state <= EN_IDLE;
        end
        KEY_LAST: begin
          if (val3 != '0) lnk.last_ch <= val3[CH_W-1:0];
          en_state <= EN_IDLE;
        end
        KEY_ENTER: begin
          // Out-of-range entries are dropped, old setting stays
          if (en_state == EN_IVAL && val6 >= IVAL_MIN_MS && val6 <= IVAL_MAX_MS) begin
            lnk.ival_ms <= val6;
          end
          if (en_state == EN_POLES && (dig[0] == 4'h0 || dig[0] == 4'h1 ||
              dig[0] == 4'h2 || dig[0] == 4'h4)) begin
            lnk.poles <= dig[0][2:0];
          end
          en_state <= EN_IDLE;
        end
        default: begin
          if (en_state == EN_PROG) begin
            en_state <= (lnk.key_code == {1'b0, PROG_POLES}) ? EN_POLES : EN_IDLE;
          end else if (lnk.key_code >= KEY_DIGIT_LIM) begin
            en_state <= EN_IDLE;
          end
        end
      endcase
    end
  end

  a_ival_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lnk.ival_ms >= IVAL_MIN_MS && lnk.ival_ms <= IVAL_MAX_MS)
    else $error("interval outside legal range");
  a_poles_legal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lnk.poles != 3'h3 && lnk.poles < 3'h5)
    else $error("illegal pole count stored");
endmodule // scs_entry
`default_nettype wire

// ### rtl/scs_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Single mode: after opening a channel, close the next for the interval, then open.
// - Single scan done at last channel: back to first channel, run lamp off.
// - Run/stop during a scan halts at current channel, kept closed, run lamp off.
// - Run/stop while halted resumes from the current channel.
// - Reset key ends any scan and returns to the first channel.
// - Continuous scan stops on run/stop, reset, program, date, time or channel key.
// - Continuous start: run lamp on with first channel closed, held for interval, then opened.
// - Continuous: after last channel opens, wrap to first channel and continue.
// - Single key selects single mode and lights its lamp.
// - Continuous key selects continuous mode and lights its lamp.
// - Channel key selects channel display; a following reset returns to first channel.
// - Channel display with no scan mode: run/stop starts step mode.
// - Pole count two makes each channel close two relay poles.
// - Three digits then first or last key store range start or end.
// - Interval key, digits, enter set dwell in seconds with three decimals.
// - Step mode: each run/stop scans exactly one channel, then advances.
// - Step mode past last channel: back to first, run lamp off.
// - Interval accepted only between 0.010 and 999.999 seconds.
// - Pole count accepts only 0, 1, 2 or 4; zero means matrix.
module scs_seq #(
  parameter int TICK_CYCLES = scs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Front panel keys
  input wire logic key_valid_i,
  input wire logic [scs_pkg::KEY_W-1:0] key_code_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [scs_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Relay cards
  output logic relay_close_o,
  output logic [scs_pkg::CH_W-1:0] relay_ch_o,
  output logic [3:0] pole_en_o,
  // Lamps
  output logic run_lamp_o,
  output logic single_lamp_o,
  output logic cont_lamp_o,
  output logic chan_lamp_o
);
  import scs_pkg::*;

  scs_link_if lnk ();
  scs_state_t state;
  scs_mode_t mode;
  scs_mode_t next_mode;
  logic [IV_W-1:0] remain;
  logic pend;
  logic [KEY_W-1:0] pend_code;
  logic kv;
  logic [KEY_W-1:0] kc;
  logic run_key;
  logic stop_key;
  logic at_last;
  logic can_start;
  logic [CH_W-1:0] next_ch;
  logic apb_acc;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return a == REG_KEY || a == REG_STATUS || a == REG_CHAN || a == REG_FIRST ||
           a == REG_LAST || a == REG_IVAL || a == REG_POLES;
  endfunction

  function automatic logic [3:0] pole_mask(input logic [2:0] p);
    case (p)
      3'h2: return 4'h3;
      3'h4: return 4'hf;
      default: return 4'h1;
    endcase
  endfunction

  scs_tick #(.TICKS(TICK_CYCLES)) u_tick (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk));
  scs_entry u_entry (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk));

  // ==========================================
  // Key merge; a panel key wins, a key written over the bus waits a cycle
  assign kv = key_valid_i | pend;
  assign kc = key_valid_i ? key_code_i : pend_code;
  assign lnk.key_v = kv;
  assign lnk.key_code = kc;
  assign lnk.tick_hold = (state != ST_DWELL);
  assign run_key = kv && kc == KEY_RUNSTOP;
  assign stop_key = kv && (kc == KEY_PROGRAM || kc == KEY_DATE ||
                           kc == KEY_TIME || kc == KEY_CHANNEL);
  assign at_last = (relay_ch_o >= lnk.last_ch);
  assign next_ch = at_last ? lnk.first_ch : relay_ch_o + 1'b1;
  assign can_start = (mode != MODE_NONE) || chan_lamp_o;
  assign apb_acc = psel_i && penable_i && pready_o;

  // ==========================================
  // Scan sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      relay_ch_o <= FIRST_RST;
      relay_close_o <= 1'b0;
      run_lamp_o <= 1'b0;
      remain <= '0;
    end else if (kv && kc == KEY_RESET) begin
      state <= ST_IDLE;
      relay_close_o <= 1'b0;
      run_lamp_o <= 1'b0;
      relay_ch_o <= lnk.first_ch;
    end else begin
      case (state)
        ST_IDLE: begin
          if (run_key && can_start) begin
            state <= ST_DWELL;
            relay_close_o <= 1'b1;
            run_lamp_o <= 1'b1;
            remain <= lnk.ival_ms;
            if (mode == MODE_SINGLE || mode == MODE_CONT) begin
              relay_ch_o <= lnk.first_ch;
            end
          end
        end
        ST_DWELL: begin
          if (run_key) begin
            state <= ST_HALT;
            run_lamp_o <= 1'b0;
          end else if (mode == MODE_CONT && stop_key) begin
            state <= ST_IDLE;
            relay_close_o <= 1'b0;
            run_lamp_o <= 1'b0;
          end else if (lnk.tick) begin
            if (remain == IV_W'(1)) begin
              state <= ST_OPEN;
              relay_close_o <= 1'b0;
            end else begin
              remain <= remain - 1'b1;
            end
          end
        end
        ST_OPEN: begin
          relay_ch_o <= next_ch;
          if (mode == MODE_CONT && stop_key) begin
            state <= ST_IDLE;
            run_lamp_o <= 1'b0;
          end else if (mode == MODE_STEP || mode == MODE_NONE ||
                       (mode == MODE_SINGLE && at_last)) begin
            state <= ST_IDLE;
            run_lamp_o <= 1'b0;
          end else begin
            state <= ST_DWELL;
            relay_close_o <= 1'b1;
            remain <= lnk.ival_ms;
          end
        end
        ST_HALT: begin
          if (run_key) begin
            state <= ST_DWELL;
            run_lamp_o <= 1'b1;
            remain <= lnk.ival_ms;
          end else if (mode == MODE_CONT && stop_key) begin
            state <= ST_IDLE;
            relay_close_o <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Scan mode; changes only when no scan is active so a running scan keeps its rules
  always_comb begin
    next_mode = mode;
    if (kv && state == ST_IDLE) begin
      case (kc)
        KEY_SINGLE: next_mode = MODE_SINGLE;
        KEY_CONT: next_mode = MODE_CONT;
        KEY_CHANNEL: next_mode = MODE_NONE;
        KEY_RUNSTOP: begin
          if (mode == MODE_NONE && chan_lamp_o) next_mode = MODE_STEP;
        end
        default: next_mode = mode;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode <= MODE_NONE;
      single_lamp_o <= 1'b0;
      cont_lamp_o <= 1'b0;
      chan_lamp_o <= 1'b1;
    end else begin
      mode <= next_mode;
      single_lamp_o <= (next_mode == MODE_SINGLE);
      cont_lamp_o <= (next_mode == MODE_CONT);
      if (kv && kc == KEY_CHANNEL) begin
        chan_lamp_o <= 1'b1;
      end else if (kv && kc == KEY_INTERVAL) begin
        chan_lamp_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pole_en_o <= 4'h1;
    end else begin
      pole_en_o <= pole_mask(lnk.poles);
    end
  end

  // ==========================================
  // APB slave, one wait state on every access
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= !reg_hit(paddr_i);
      prdata_o <= '0;
      if (!pwrite_i) begin
        case (paddr_i)
          REG_STATUS: prdata_o <= {23'h000000, chan_lamp_o, cont_lamp_o, single_lamp_o,
                                   run_lamp_o, mode, state, relay_close_o};
          REG_CHAN: prdata_o <= {22'h000000, relay_ch_o};
          REG_FIRST: prdata_o <= {22'h000000, lnk.first_ch};
          REG_LAST: prdata_o <= {22'h000000, lnk.last_ch};
          REG_IVAL: prdata_o <= {12'h000, lnk.ival_ms};
          REG_POLES: prdata_o <= {29'h00000000, lnk.poles};
          default: prdata_o <= '0;
        endcase
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend <= 1'b0;
      pend_code <= '0;
    end else if (apb_acc && pwrite_i && paddr_i == REG_KEY) begin
      pend <= 1'b1;
      pend_code <= pwdata_i[KEY_W-1:0];
    end else if (!key_valid_i) begin
      pend <= 1'b0;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_dwell_end;
    state == ST_DWELL && lnk.tick && remain == IV_W'(1) && !run_key && !stop_key
    && !(kv && kc == KEY_RESET);
  endsequence
  sequence s_open_gap;
    !relay_close_o && state == ST_OPEN ##1 (relay_close_o || state == ST_IDLE);
  endsequence

  a_dwell_then_open: assert property (s_dwell_end |=> s_open_gap)
    else $error("channel not opened after dwell");
  a_single_wrap: assert property (state == ST_OPEN && mode == MODE_SINGLE && at_last
    && !stop_key |=> state == ST_IDLE && relay_ch_o == $past(lnk.first_ch) && !run_lamp_o)
    else $error("single scan end wrong");
  a_halt_holds: assert property (state == ST_DWELL && run_key && !(kc == KEY_RESET)
    |=> state == ST_HALT && relay_close_o && !run_lamp_o && $stable(relay_ch_o))
    else $error("halt did not hold channel");
  a_resume_here: assert property (state == ST_HALT && run_key
    |=> state == ST_DWELL && run_lamp_o && $stable(relay_ch_o))
    else $error("resume moved channel");
  a_reset_first: assert property (kv && kc == KEY_RESET
    |=> state == ST_IDLE && !relay_close_o && relay_ch_o == $past(lnk.first_ch))
    else $error("reset did not return to first channel");
  a_cont_stop: assert property (state == ST_DWELL && mode == MODE_CONT && stop_key
    && !run_key |=> state == ST_IDLE && !relay_close_o
    ##1 (state == ST_IDLE || $past(run_key)))
    else $error("continuous scan not stopped");
  a_cont_start: assert property (state == ST_IDLE && mode == MODE_CONT && run_key
    |=> run_lamp_o && relay_close_o && relay_ch_o == $past(lnk.first_ch))
    else $error("continuous start wrong");
  a_cont_wrap: assert property (state == ST_OPEN && mode == MODE_CONT && at_last
    && !stop_key && !(kv && kc == KEY_RESET)
    |=> state == ST_DWELL && relay_close_o && relay_ch_o == $past(lnk.first_ch))
    else $error("continuous scan did not wrap");
  a_step_once: assert property (state == ST_OPEN && mode == MODE_STEP
    |=> state == ST_IDLE && !run_lamp_o && !relay_close_o)
    else $error("step mode scanned more than one channel");
  a_mode_lamps: assert property ((single_lamp_o == (mode == MODE_SINGLE))
    && (cont_lamp_o == (mode == MODE_CONT)))
    else $error("mode lamps disagree with mode");
  a_step_start: assert property (state == ST_IDLE && mode == MODE_NONE && chan_lamp_o
    && run_key |=> mode == MODE_STEP && state == ST_DWELL)
    else $error("step mode not started");
  a_two_pole: assert property (lnk.poles == 3'h2 |=> pole_en_o == 4'h3)
    else $error("two-pole mask wrong");
endmodule // scs_seq
`default_nettype wire

// ### tb/scs_panel.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Front panel keypad and relay card monitor
module scs_panel (
  // Clock
  input wire logic clk_i,
  // Relay card side
  input wire logic relay_close_i,
  input wire logic [scs_pkg::CH_W-1:0] relay_ch_i,
  // Keys
  output logic key_valid_o,
  output logic [scs_pkg::KEY_W-1:0] key_code_o
);
  import scs_pkg::*;
  int n_close = 0;
  int dwell = 0;
  int cnt = 0;
  logic was = 1'b0;
  logic [CH_W-1:0] seen [8];
  initial begin
    key_valid_o = 1'b0;
    key_code_o = 5'h00;
  end
  // ==========================================
  // One key per press; code is changed when idle so a stale code never looks valid
  task press(input logic [KEY_W-1:0] k);
    @(posedge clk_i);
    key_valid_o <= 1'b1;
    key_code_o <= k;
    @(posedge clk_i);
    key_valid_o <= 1'b0;
    key_code_o <= ~k;
    @(posedge clk_i);
    #1;
  endtask
  // ==========================================
  // Card logs each closure and its length in cycles
  always @(posedge clk_i) begin
    was <= relay_close_i;
    if (relay_close_i && !was) begin
      seen[n_close % 8] <= relay_ch_i;
      n_close <= n_close + 1;
      cnt <= 1;
    end else if (relay_close_i) begin
      cnt <= cnt + 1;
    end else if (was) begin
      dwell <= cnt;
    end
  end
endmodule // scs_panel
`default_nettype wire

// ### tb/channel_scan_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module channel_scan_sequencer_tb;
  import scs_pkg::*;
  // Short tick keeps a 10 ms dwell at 40 cycles
  localparam int TK = 4;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, er, kv, rc, rl, sl, cl, hl;
  logic [KEY_W-1:0] kc;
  logic [CH_W-1:0] ch;
  logic [3:0] pe;
  int n_fail = 0;
  int total_checks = 0;
  int base;
  logic [KEY_W-1:0] stk [4] = '{KEY_PROGRAM, KEY_DATE, KEY_TIME, KEY_CHANNEL};
  always #2.5 clk_i = ~clk_i;
  scs_seq #(.TICK_CYCLES(TK)) scs_seq_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .key_valid_i(kv), .key_code_i(kc), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .relay_close_o(rc), .relay_ch_o(ch),
    .pole_en_o(pe), .run_lamp_o(rl), .single_lamp_o(sl), .cont_lamp_o(cl),
    .chan_lamp_o(hl));
  scs_panel scs_panel_i (.clk_i(clk_i), .relay_close_i(rc), .relay_ch_i(ch),
    .key_valid_o(kv), .key_code_o(kc));
  // ==========================================
  // Tasks
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Close, run, single, cont, channel lamps, then channel
  function automatic logic [31:0] e(logic c, logic [3:0] l, logic [9:0] n);
    return {17'h0, c, l, n};
  endfunction
  function automatic logic [31:0] st();
    return {17'h0, rc, rl, sl, cl, hl, ch};
  endfunction
  // Pready and data are taken at the edge itself; only the watchdog ends a hung wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task keys(input logic [KEY_W-1:0] k [8], input int n);
    for (int i = 0; i < n; i++) scs_panel_i.press(k[i]);
  endtask
  task wait_off();
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      #1;
      if (rl === 1'b0) break;
    end
  endtask
  // ==========================================
  // Tests
  initial begin
    #60us;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(st(), e(1'b0, 4'b0001, 10'd1));
    chk(pe, 4'b0001);
    rchk(REG_STATUS, 32'h100);
    apb(1'b0, 8'h1c, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    keys('{KEY_PROGRAM, 5'h06, 5'h02, KEY_ENTER, 0, 0, 0, 0}, 4);
    chk(pe, 4'b0011);
    keys('{KEY_PROGRAM, 5'h06, 5'h03, KEY_ENTER, 0, 0, 0, 0}, 4);
    rchk(REG_POLES, 32'h2);
    keys('{KEY_PROGRAM, 5'h06, 5'h04, KEY_ENTER, 0, 0, 0, 0}, 4);
    chk(pe, 4'b1111);
    keys('{5'h00, 5'h00, 5'h03, KEY_FIRST, 5'h00, 5'h00, 5'h05, KEY_LAST}, 8);
    rchk(REG_FIRST, 32'h3);
    rchk(REG_LAST, 32'h5);
    keys('{KEY_INTERVAL, 0, 0, 0, 0, 5'h01, 0, KEY_ENTER}, 8);
    keys('{KEY_INTERVAL, 0, 0, 0, 0, 0, 5'h09, KEY_ENTER}, 8);
    rchk(REG_IVAL, 32'ha);
    $display("config test done");
    scs_panel_i.press(KEY_SINGLE);
    chk(st() & 32'h7c00, e(1'b0, 4'b0100, 10'd0));
    base = scs_panel_i.n_close;
    scs_panel_i.press(KEY_RUNSTOP);
    chk(st(), e(1'b1, 4'b1100, 10'd3));
    wait_off();
    chk(st(), e(1'b0, 4'b0100, 10'd3));
    for (int i = 0; i < 3; i++) chk(scs_panel_i.seen[(base + i) % 8], 3 + i);
    chk(scs_panel_i.dwell >= 37 && scs_panel_i.dwell <= 42, 1);
    $display("single test done");
    scs_panel_i.press(KEY_RUNSTOP);
    repeat (10) @(posedge clk_i);
    scs_panel_i.press(KEY_RUNSTOP);
    chk(st(), e(1'b1, 4'b0100, 10'd3));
    repeat (60) @(posedge clk_i);
    chk(st(), e(1'b1, 4'b0100, 10'd3));
    scs_panel_i.press(KEY_RUNSTOP);
    chk(st(), e(1'b1, 4'b1100, 10'd3));
    for (int i = 0; i < 100 && ch !== 10'd4; i++) @(posedge clk_i);
    apb(1'b1, REG_KEY, {27'h0, KEY_RESET});
    repeat (3) @(posedge clk_i);
    #1;
    chk({rc, rl, ch}, {1'b0, 1'b0, 10'd3});
    rchk(REG_CHAN, 32'h3);
    $display("halt test done");
    scs_panel_i.press(KEY_CONT);
    chk(st() & 32'h7c00, e(1'b0, 4'b0010, 10'd0));
    base = scs_panel_i.n_close;
    scs_panel_i.press(KEY_RUNSTOP);
    chk(st(), e(1'b1, 4'b1010, 10'd3));
    for (int i = 0; i < 400 && scs_panel_i.n_close < base + 4; i++) @(posedge clk_i);
    chk({rl, scs_panel_i.seen[(base + 3) % 8]}, {1'b1, 10'd3});
    for (int i = 0; i < 4; i++) begin
      scs_panel_i.press(stk[i]);
      chk({rc, rl}, 2'b00);
      if (i < 3) keys('{KEY_CONT, KEY_RUNSTOP, 0, 0, 0, 0, 0, 0}, 2);
    end
    $display("continuous test done");
    // A channel key during a running scan stops it and lights its lamp; mode falls back on the next one, pressed while idle
    scs_panel_i.press(KEY_CHANNEL);
    chk(st() & 32'h7c00, e(1'b0, 4'b0001, 10'd0));
    scs_panel_i.press(KEY_RESET);
    chk(st(), e(1'b0, 4'b0001, 10'd3));
    scs_panel_i.press(KEY_RUNSTOP);
    chk(st(), e(1'b1, 4'b1001, 10'd3));
    wait_off();
    chk(st(), e(1'b0, 4'b0001, 10'd4));
    for (int i = 0; i < 2; i++) begin
      scs_panel_i.press(KEY_RUNSTOP);
      wait_off();
    end
    chk(st(), e(1'b0, 4'b0001, 10'd3));
    $display("step test done");
    end_sim();
  end
endmodule // channel_scan_sequencer_tb
`default_nettype wire
